// [core/aar_pkg.sv]
// Shared constants of the auto-negotiation advertisement register bank.
// Assumes a 32-bit APB register port with 12-bit byte addresses.
package aar_pkg;

    // Byte offsets of the APB registers
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_ADVERT = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_PAGE = 12'h058;

    // Control register field positions
    localparam int CTRL_SW_RESET = 15;
    localparam int CTRL_SPEED_LSB = 13;
    localparam int CTRL_AN_ENABLE = 12;
    localparam int CTRL_POWER_DOWN = 11;
    localparam int CTRL_AN_RESTART = 9;
    localparam int CTRL_DUPLEX = 8;
    localparam int CTRL_SPEED_MSB = 6;

    // Control reset values
    localparam logic CTRL_AN_ENABLE_RST = 1'h1;
    localparam logic CTRL_POWER_DOWN_RST = 1'h0;
    localparam logic CTRL_DUPLEX_RST = 1'h1;
    localparam logic CTRL_SPEED_LSB_RST = 1'h0;
    localparam logic CTRL_SPEED_MSB_RST = 1'h1;

    // Copper advertisement fields
    localparam int COP_10_HALF = 5;
    localparam int COP_SEL_MSB = 4;
    localparam logic [4:0] SELECTOR_8023 = 5'h01;

    // Fiber advertisement fields
    localparam int FIB_NEXT_PAGE = 15;
    localparam int FIB_RFAULT_LSB = 12;
    localparam int FIB_PAUSE_LSB = 7;
    localparam logic FIB_NEXT_PAGE_RST = 1'h0;
    localparam logic [1:0] FIB_RFAULT_RST = 2'h0;
    localparam logic [1:0] PAUSE_RST_OFF = 2'h0;
    localparam logic [1:0] PAUSE_RST_ON = 2'h3;

    // Remote fault encodings
    localparam logic [1:0] RFAULT_NONE = 2'h0;
    localparam logic [1:0] RFAULT_LINK_FAIL = 2'h1;
    localparam logic [1:0] RFAULT_OFFLINE = 2'h2;
    localparam logic [1:0] RFAULT_AN_ERROR = 2'h3;

    // Status register extra bits
    localparam int STAT_LINK_UP = 16;
    localparam int STAT_GBIC = 17;
    localparam int STAT_FORCED_1000 = 18;

    // Configuration encodings
    localparam logic [3:0] HWCFG_GBIC = 4'h8;
    localparam int SYNC_W = 10;

    typedef enum logic {
        AAR_PAGE_COPPER,
        AAR_PAGE_FIBER
    } aar_page_e;

endpackage : aar_pkg

// [core/aar_sync.sv]
// Two-flop synchroniser for strap and link pins.
// Assumes the inputs are quasi-static or level signals.
`timescale 1ns/100ps
module aar_sync
    import aar_pkg::*;
#(
    parameter int W = SYNC_W
) (
    // Clock
    input wire logic clock,
    // Asynchronous inputs and synchronised copy
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // No reset here so straps are already settled when rst releases
    always_ff @(posedge clock) begin
        meta_q <= async_in;
        sync_q <= meta_q;
    end

    assign sync_out = sync_q;

endmodule // aar_sync

// [core/aar_trigger.sv]
// Detects the events that commit pending advertisement values.
// Assumes all inputs are synchronous to clock.
`timescale 1ns/100ps
module aar_trigger
    import aar_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Event sources
    input wire logic sw_reset_pulse,
    input wire logic restart_pulse,
    input wire logic power_down,
    input wire logic link_up,
    // Commit strobe
    output logic apply
);

    logic power_down_q;
    logic link_up_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            power_down_q <= CTRL_POWER_DOWN_RST;
            link_up_q <= 1'h0;
        end else begin
            power_down_q <= power_down;
            link_up_q <= link_up;
        end
    end

    assign apply = sw_reset_pulse | restart_pulse
        | (power_down_q & ~power_down) | (link_up_q & ~link_up);

endmodule // aar_trigger

// [core/aar_regs.sv]
// Auto-negotiation advertisement register bank, copper and fiber pages.
// Assumes an APB master on clock, straps stable around reset release.
//
// What this block does
// - Written advertisement applies only on reset, restart, power-up or link loss.
// - In GBIC mode writes to copper 10 half-duplex bit are ignored.
// - Forced 1000 keeps autoneg running, advertising duplex set by control.
// - Forced 1000 ignores copper 10/100 and 1000BASE-T advertisement bits.
// - Copper 10 half-duplex reset default comes from strap decode.
// - Fiber next page resets to 0, retained on software reset.
// - Remote fault encodes none, link fail, offline, autoneg error.
// - Remote fault is never set by the device itself.
// - Pause field encodes none, symmetric, asymmetric, both.
// - Pause resets to 00 or 11 from strap, kept on software reset.
`timescale 1ns/100ps
module aar_regs
    import aar_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Straps and line state from pins
    input wire logic [3:0] autoneg_config_straps,
    input wire logic [3:0] hardware_config_select,
    input wire logic pause_default_strap,
    input wire logic link_up,
    // Active copper advertisement
    output logic copper_adv_10_half,
    output logic [4:0] copper_selector,
    output logic adv_override,
    output logic adv_1000t_full,
    output logic adv_1000t_half,
    output logic autoneg_running,
    // Active fiber advertisement
    output logic fiber_next_page,
    output logic [1:0] fiber_remote_fault,
    output logic [1:0] fiber_pause
);

    // Seven-pin strap decode for the copper 10 half-duplex default
    function automatic logic cop10_default(input logic [3:0] aneg,
                                           input logic [3:0] hw);
        logic aneg_ok;
        logic hw_ok;
        aneg_ok = (aneg == 4'h0) || (aneg[3:2] == 2'h3);
        hw_ok = hw[3] && (hw[1:0] == 2'h3);
        return aneg_ok && hw_ok;
    endfunction

    // Forced-1000 condition from control bits
    function automatic logic forced_1000(input logic an_en,
                                         input logic spd_msb,
                                         input logic spd_lsb);
        return !an_en && spd_msb && !spd_lsb;
    endfunction

    // Synchronised pins
    logic [SYNC_W-1:0] pins_s;
    logic [3:0] aneg_s;
    logic [3:0] hwcfg_s;
    logic pause_strap_s;
    logic link_up_s;

    aar_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clock(clock),
        .async_in({link_up, pause_default_strap,
                   hardware_config_select, autoneg_config_straps}),
        .sync_out(pins_s)
    );

    assign aneg_s = pins_s[3:0];
    assign hwcfg_s = pins_s[7:4];
    assign pause_strap_s = pins_s[8];
    assign link_up_s = pins_s[9];

    // APB decode
    logic setup;
    logic access;
    logic wr_en;
    logic sel_ctrl;
    logic sel_advert;
    logic sel_status;
    logic sel_page;
    logic mapped;
    logic lane1;
    logic lane0;

    assign setup = psel && !penable;
    assign access = psel && penable;

    always_comb begin
        sel_ctrl = 1'h0;
        sel_advert = 1'h0;
        sel_status = 1'h0;
        sel_page = 1'h0;
        if (paddr == ADDR_CTRL) begin
            sel_ctrl = 1'h1;
        end else if (paddr == ADDR_ADVERT) begin
            sel_advert = 1'h1;
        end else if (paddr == ADDR_STATUS) begin
            sel_status = 1'h1;
        end else if (paddr == ADDR_PAGE) begin
            sel_page = 1'h1;
        end
    end

    assign mapped = sel_ctrl | sel_advert | sel_status | sel_page;
    assign wr_en = access && pwrite && mapped;
    assign lane1 = pstrb[1];
    assign lane0 = pstrb[0];
    assign pready = 1'h1;
    assign pslverr = access && !mapped;

    // Page select
    aar_page_e page_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            page_q <= AAR_PAGE_COPPER;
        end else if (wr_en && sel_page && lane0) begin
            page_q <= pwdata[0] ? AAR_PAGE_FIBER : AAR_PAGE_COPPER;
        end
    end

    // Control register
    logic an_enable_q;
    logic power_down_q;
    logic duplex_q;
    logic speed_lsb_q;
    logic speed_msb_q;
    logic sw_reset_q;
    logic restart_q;
    logic forced_1000_w;

    always_ff @(posedge clock) begin
        if (rst) begin
            an_enable_q <= CTRL_AN_ENABLE_RST;
            power_down_q <= CTRL_POWER_DOWN_RST;
            duplex_q <= CTRL_DUPLEX_RST;
            speed_lsb_q <= CTRL_SPEED_LSB_RST;
            speed_msb_q <= CTRL_SPEED_MSB_RST;
        end else if (wr_en && sel_ctrl) begin
            if (lane1) begin
                an_enable_q <= pwdata[CTRL_AN_ENABLE];
                power_down_q <= pwdata[CTRL_POWER_DOWN];
                duplex_q <= pwdata[CTRL_DUPLEX];
                speed_lsb_q <= pwdata[CTRL_SPEED_LSB];
            end
            if (lane0) begin
                speed_msb_q <= pwdata[CTRL_SPEED_MSB];
            end
        end
    end

    // Self-clearing strobes, one cycle after the write
    always_ff @(posedge clock) begin
        if (rst) begin
            sw_reset_q <= 1'h0;
            restart_q <= 1'h0;
        end else begin
            sw_reset_q <= wr_en && sel_ctrl && lane1
                && pwdata[CTRL_SW_RESET];
            restart_q <= wr_en && sel_ctrl && lane1
                && pwdata[CTRL_AN_RESTART];
        end
    end

    assign forced_1000_w = forced_1000(an_enable_q, speed_msb_q,
                                       speed_lsb_q);

    // Commit event detection
    logic apply;

    aar_trigger u_trigger (
        .clock(clock),
        .rst(rst),
        .sw_reset_pulse(sw_reset_q),
        .restart_pulse(restart_q),
        .power_down(power_down_q),
        .link_up(link_up_s),
        .apply(apply)
    );

    // Pending copies, read back at once
    logic gbic_mode;
    logic wr_copper;
    logic wr_fiber;
    logic cop10_pend_q;
    logic np_pend_q;
    logic [1:0] rf_pend_q;
    logic [1:0] pause_pend_q;

    assign gbic_mode = (hwcfg_s == HWCFG_GBIC);
    assign wr_copper = wr_en && sel_advert && page_q == AAR_PAGE_COPPER;
    assign wr_fiber = wr_en && sel_advert && page_q == AAR_PAGE_FIBER;

    always_ff @(posedge clock) begin
        if (rst) begin
            cop10_pend_q <= cop10_default(aneg_s, hwcfg_s);
        end else if (wr_copper && lane0 && !gbic_mode) begin
            cop10_pend_q <= pwdata[COP_10_HALF];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            np_pend_q <= FIB_NEXT_PAGE_RST;
        end else if (wr_fiber && lane1) begin
            np_pend_q <= pwdata[FIB_NEXT_PAGE];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rf_pend_q <= FIB_RFAULT_RST;
        end else if (wr_fiber && lane1) begin
            rf_pend_q <= pwdata[FIB_RFAULT_LSB+:2];
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pause_pend_q <= pause_strap_s ? PAUSE_RST_ON : PAUSE_RST_OFF;
        end else if (wr_fiber) begin
            if (lane1) begin
                pause_pend_q[1] <= pwdata[FIB_PAUSE_LSB+1];
            end
            if (lane0) begin
                pause_pend_q[0] <= pwdata[FIB_PAUSE_LSB];
            end
        end
    end

    // Active advertisement
    logic cop10_act_q;
    logic np_act_q;
    logic [1:0] rf_act_q;
    logic [1:0] pause_act_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            cop10_act_q <= cop10_default(aneg_s, hwcfg_s);
            np_act_q <= FIB_NEXT_PAGE_RST;
            rf_act_q <= FIB_RFAULT_RST;
            pause_act_q <= pause_strap_s ? PAUSE_RST_ON : PAUSE_RST_OFF;
        end else if (apply) begin
            // Software reset commits but keeps values
            cop10_act_q <= cop10_pend_q;
            np_act_q <= np_pend_q;
            rf_act_q <= rf_pend_q;
            pause_act_q <= pause_pend_q;
        end
    end

    // Read images of both pages
    logic [15:0] copper_img;
    logic [15:0] fiber_img;
    logic [15:0] copper_act_img;
    logic [15:0] fiber_act_img;

    always_comb begin
        copper_img = 16'h0000;
        copper_img[COP_SEL_MSB:0] = SELECTOR_8023;
        copper_img[COP_10_HALF] = cop10_pend_q;
        copper_act_img = copper_img;
        copper_act_img[COP_10_HALF] = cop10_act_q;
    end

    always_comb begin
        fiber_img = 16'h0000;
        fiber_img[FIB_NEXT_PAGE] = np_pend_q;
        fiber_img[FIB_RFAULT_LSB+:2] = rf_pend_q;
        fiber_img[FIB_PAUSE_LSB+:2] = pause_pend_q;
        fiber_act_img = 16'h0000;
        fiber_act_img[FIB_NEXT_PAGE] = np_act_q;
        fiber_act_img[FIB_RFAULT_LSB+:2] = rf_act_q;
        fiber_act_img[FIB_PAUSE_LSB+:2] = pause_act_q;
    end

    // Read mux
    logic [31:0] rdata_d;
    logic [31:0] prdata_q;

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (sel_ctrl) begin
            rdata_d[CTRL_SPEED_LSB] = speed_lsb_q;
            rdata_d[CTRL_AN_ENABLE] = an_enable_q;
            rdata_d[CTRL_POWER_DOWN] = power_down_q;
            rdata_d[CTRL_DUPLEX] = duplex_q;
            rdata_d[CTRL_SPEED_MSB] = speed_msb_q;
        end else if (sel_advert) begin
            rdata_d[15:0] = (page_q == AAR_PAGE_FIBER) ? fiber_img
                                                       : copper_img;
        end else if (sel_status) begin
            rdata_d[15:0] = (page_q == AAR_PAGE_FIBER) ? fiber_act_img
                                                       : copper_act_img;
            rdata_d[STAT_LINK_UP] = link_up_s;
            rdata_d[STAT_GBIC] = gbic_mode;
            rdata_d[STAT_FORCED_1000] = forced_1000_w;
        end else if (sel_page) begin
            rdata_d[0] = (page_q == AAR_PAGE_FIBER);
        end
    end

    // Read data is sampled in the setup cycle so it comes from a flop
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_q <= rdata_d;
        end
    end

    assign prdata = prdata_q;

    assign autoneg_running = an_enable_q | forced_1000_w;
    assign adv_1000t_full = forced_1000_w & duplex_q;
    assign adv_1000t_half = forced_1000_w & ~duplex_q;

    assign adv_override = forced_1000_w;
    assign copper_adv_10_half = cop10_act_q & ~forced_1000_w;
    assign copper_selector = SELECTOR_8023;

    assign fiber_next_page = np_act_q;
    assign fiber_remote_fault = rf_act_q;
    assign fiber_pause = pause_act_q;

endmodule // aar_regs

// [dv/aar_regs_monitor.sv]
// Port checker for the advertisement register bank.
// Bound to aar_regs; sees only that module's ports.
`timescale 1ns/100ps
module aar_regs_monitor
    import aar_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic [3:0] autoneg_config_straps,
    input wire logic [3:0] hardware_config_select,
    input wire logic pause_default_strap,
    input wire logic link_up,
    // Active advertisement
    input wire logic copper_adv_10_half,
    input wire logic [4:0] copper_selector,
    input wire logic adv_override,
    input wire logic adv_1000t_full,
    input wire logic adv_1000t_half,
    input wire logic autoneg_running,
    input wire logic fiber_next_page,
    input wire logic [1:0] fiber_remote_fault,
    input wire logic [1:0] fiber_pause
);
    logic mapped, ten_half_exp, link_prev_q;
    logic [3:0] evt_age_q;
    logic [8:0] straps, strap_prev_q;
    logic [2:0] strap_age_q;

    assign straps = {autoneg_config_straps, hardware_config_select,
        pause_default_strap};
    assign mapped = paddr inside {ADDR_CTRL, ADDR_ADVERT, ADDR_STATUS,
        ADDR_PAGE};
    assign ten_half_exp = (autoneg_config_straps == 4'h0 ||
        autoneg_config_straps[3:2] == 2'h3) && hardware_config_select[3] &&
        hardware_config_select[1:0] == 2'h3;

    // Any control write or link drop may commit, so age counts from those
    always_ff @(posedge clock) begin
        link_prev_q <= link_up;
        if (rst || (psel && penable && pwrite && paddr == ADDR_CTRL) ||
                (link_prev_q && !link_up)) begin
            evt_age_q <= 4'h0;
        end else if (evt_age_q != 4'hf) begin
            evt_age_q <= evt_age_q + 4'h1;
        end
    end

    // Defaults are only defined once the straps have settled
    always_ff @(posedge clock) begin
        strap_prev_q <= straps;
        if (straps !== strap_prev_q) begin
            strap_age_q <= 3'h0;
        end else if (strap_age_q != 3'h7) begin
            strap_age_q <= strap_age_q + 3'h1;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_rst_rel;
        $fell(rst);
    endsequence
    sequence s_calm;
        strap_age_q >= 3'h5;
    endsequence

    property p_ready;
        psel && penable |-> pready;
    endproperty
    property p_err;
        psel && penable |-> pslverr == !mapped;
    endproperty
    property p_rd_zero;
        psel && penable && !pwrite && !mapped |-> prdata == 32'h0;
    endproperty
    property p_selector;
        !rst |=> copper_selector == SELECTOR_8023;
    endproperty
    property p_forced_one;
        adv_override |-> (adv_1000t_full ^ adv_1000t_half) && autoneg_running;
    endproperty
    property p_forced_only;
        adv_1000t_full || adv_1000t_half |-> adv_override;
    endproperty
    property p_ignore_bits;
        adv_override |-> !copper_adv_10_half;
    endproperty
    property p_commit_only;
        $changed({copper_adv_10_half, fiber_next_page, fiber_remote_fault,
            fiber_pause}) |-> evt_age_q <= 4'h6;
    endproperty
    property p_hw_default;
        s_rst_rel ##0 s_calm |-> copper_adv_10_half == ten_half_exp &&
            fiber_pause == {2{pause_default_strap}} && !fiber_next_page &&
            fiber_remote_fault == RFAULT_NONE;
    endproperty

    a_ready: assert property (p_ready) else $error("pready low in access");
    a_err: assert property (p_err) else $error("pslverr wrong");
    a_rd_zero: assert property (p_rd_zero) else $error("unmapped read data");
    a_selector: assert property (p_selector)
        else $error("selector not 802.3");
    a_forced_one: assert property (p_forced_one)
        else $error("forced 1000 duplex advert wrong");
    a_forced_only: assert property (p_forced_only)
        else $error("1000T advert without forcing");
    a_ignore_bits: assert property (p_ignore_bits)
        else $error("10 half advertised while forced");
    a_commit_only: assert property (p_commit_only)
        else $error("advertisement changed without commit");
    a_hw_default: assert property (p_hw_default)
        else $error("hardware reset default wrong");
endmodule // aar_regs_monitor

bind aar_regs aar_regs_monitor i_mon (.clock, .rst, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .autoneg_config_straps,
    .hardware_config_select, .pause_default_strap, .link_up,
    .copper_adv_10_half, .copper_selector, .adv_override, .adv_1000t_full,
    .adv_1000t_half, .autoneg_running, .fiber_next_page, .fiber_remote_fault,
    .fiber_pause);

// [dv/aar_regs_tb.sv]
// Self-checking bench for the advertisement register bank.
// Drives APB, straps and link itself; no partner model.
`timescale 1ns/100ps
module aar_regs_tb;
    import aar_pkg::*;
    localparam logic [31:0] IDLE = (32'h1 << CTRL_AN_ENABLE) |
        (32'h1 << CTRL_DUPLEX) | (32'h1 << CTRL_SPEED_MSB);
    localparam logic [31:0] RESTART = IDLE | (32'h1 << CTRL_AN_RESTART);
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [3:0] an = 4'h0;
    logic [3:0] hw = 4'hb;
    logic ps = 1'b1;
    logic link_up = 1'b1;
    logic [31:0] prdata, r, v, old;
    logic pready, pslverr, c10, ovr, f1000, h1000, anr, np;
    logic [1:0] rf, pz;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h5a171d69;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;

    aar_regs i_dut (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .autoneg_config_straps(an), .hardware_config_select(hw),
        .pause_default_strap(ps), .link_up(link_up),
        .copper_adv_10_half(c10), .copper_selector(), .adv_override(ovr),
        .adv_1000t_full(f1000), .adv_1000t_half(h1000),
        .autoneg_running(anr), .fiber_next_page(np),
        .fiber_remote_fault(rf), .fiber_pause(pz));

    always #5 clock = ~clock;

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction

    task automatic wrap_up();
        // A read whose data never came back is a miss as well
        if (exp_q.size() != 0) begin
            n_mismatch++;
        end
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Holds the request until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        chk(32'(pslverr), 32'(!(a inside {ADDR_CTRL, ADDR_ADVERT,
            ADDR_STATUS, ADDR_PAGE})));
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so a following call never reassigns psel in this step
        @(posedge clock);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic fib(input logic [31:0] w);
        @(negedge clock);
        chk(32'({np, rf, pz}), 32'({w[15], w[13:12], w[8:7]}));
        @(posedge clock);
    endtask

    task automatic do_reset(input logic [3:0] a, input logic [3:0] h,
            input logic p);
        logic d;
        d = (a == 4'h0 || a[3:2] == 2'h3) && h[3] && h[1:0] == 2'h3;
        an <= a;
        hw <= h;
        ps <= p;
        tick(4);
        rst <= 1'b1;
        tick(3);
        rst <= 1'b0;
        @(negedge clock);
        chk(32'(c10), 32'(d));
        chk(32'({np, rf, pz}), {27'h0, 3'h0, p, p});
        @(posedge clock);
        rd(ADDR_ADVERT, {26'h0, d, SELECTOR_8023});
    endtask

    always @(posedge clock) begin
        if (psel && penable && !pwrite && pready === 1'b1 &&
                exp_q.size() > 0) begin
            chk(prdata, exp_q.pop_front());
        end
    end

    always @(posedge clock) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        tick(3);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            r = seed;
            do_reset(r[5] ? {2'h3, r[7:6]} : (r[8] ? 4'h0 : r[9:6]),
                (i == 5) ? HWCFG_GBIC : (r[4] ? (r[3:0] | 4'hb) : r[3:0]),
                r[10]);
        end
        wr_gbic: begin
            apb(1'b1, ADDR_ADVERT, 32'h20);
            rd(ADDR_ADVERT, 32'h1);
            apb(1'b1, ADDR_CTRL, RESTART);
            tick(3);
            chk(32'(c10), 32'h0);
            fib({23'h0, ps, ps, 7'h0});
        end
        do_reset(4'h0, 4'hb, 1'b1);
        apb(1'b1, ADDR_ADVERT, 32'h0);
        rd(ADDR_ADVERT, 32'h1);
        @(negedge clock);
        chk(32'(c10), 32'h1);
        @(posedge clock);
        apb(1'b1, ADDR_CTRL, RESTART);
        @(negedge clock);
        chk(32'(c10), 32'h0);
        @(posedge clock);
        apb(1'b1, ADDR_PAGE, 32'h1);
        old = 32'h180;
        for (int i = 0; i < 4; i++) begin
            v = {16'h0, i[0], 1'b0, i[1:0], 3'h0, 2'(i + 1), 7'h0};
            apb(1'b1, ADDR_ADVERT, v);
            rd(ADDR_ADVERT, v);
            fib(old);
            case (i)
            0: apb(1'b1, ADDR_CTRL, RESTART);
            1: apb(1'b1, ADDR_CTRL, IDLE | (32'h1 << CTRL_SW_RESET));
            2: begin
                apb(1'b1, ADDR_CTRL, IDLE | (32'h1 << CTRL_POWER_DOWN));
                tick(6);
                fib(old);
                apb(1'b1, ADDR_CTRL, IDLE);
            end
            default: begin
                link_up <= 1'b0;
                tick(6);
                link_up <= 1'b1;
            end
            endcase
            tick(6);
            fib(v);
            rd(ADDR_STATUS, v | (32'h1 << STAT_LINK_UP));
            old = v;
        end
        apb(1'b1, ADDR_PAGE, 32'h0);
        apb(1'b1, ADDR_ADVERT, 32'h20);
        apb(1'b1, ADDR_CTRL, RESTART);
        for (int d = 0; d < 3; d++) begin
            v = (d == 2) ? 32'h0 : ((32'h1 << CTRL_SPEED_MSB) |
                (32'(d) << CTRL_DUPLEX));
            apb(1'b1, ADDR_CTRL, v);
            tick(3);
            @(negedge clock);
            chk(32'({ovr, f1000, h1000, anr, c10}), (d == 2) ? 32'h1 :
                {27'h0, 1'b1, d[0], ~d[0], 2'b10});
            @(posedge clock);
        end
        apb(1'b1, ADDR_CTRL, IDLE);
        apb(1'b1, 12'h100, 32'hffff_ffff);
        rd(12'h100, 32'h0);
        rd(ADDR_ADVERT, 32'h21);
        @(negedge clock);
        chk(32'({ovr, anr, c10}), 32'h3);
        wrap_up();
    end
endmodule // aar_regs_tb
